// >>> core/pdc_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"
// Function
// [RL1] Separate transmit and receive enable bits
// [RL2] Transmit teardown by writing channel 0..7
// [RL3] Receive teardown by writing channel 0..7
// [RL4] Teardown registers always read zero
// [RL5] Teardown ready reads zero, assumed one
// [RL6] Read-only identity and version per direction
// [RL7] Writing one resets whole controller logic; request buffer and answer register keep state
// [RL8] Reset waits until both directions idle
// [RL9] Reset bit reads one while pending
// [RL10] Copy-overrun bit keeps or discards overrun frames
// [RL11] Copy-overrun bit ignores other error kinds
// [RL12] Idle command bit, zero requests idle
// [RL13] Block bit suppresses descriptor length writes
// [RL14] Clear block bit allows descriptor length writes
// [RL15] Ownership write value follows control bit
// [RL16] Arbitration: round-robin or fixed, seven highest
// [RL17] Status idle flag when no transfer
// [RL18] Reserved bits read zero, writes ignored
module pdc_device
    import pdc_pkg::*;
#(
    parameter int          DEPTH    = 2,
    parameter logic [15:0] TX_IDENT = 16'h1234, // Arbitrary value
    parameter logic [7:0]  TX_MAJOR = 8'h01,    // Arbitrary value
    parameter logic [7:0]  TX_MINOR = 8'h00,    // Arbitrary value
    parameter logic [15:0] RX_IDENT = 16'h1235, // Arbitrary value
    parameter logic [7:0]  RX_MAJOR = 8'h01,    // Arbitrary value
    parameter logic [7:0]  RX_MINOR = 8'h00     // Arbitrary value
)
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    pdc_if.device           bus,
    input  wire logic       tx_active,
    input  wire logic       rx_active,
    input  wire logic [7:0] tx_channel_pending,
    input  wire logic       tx_channel_take,
    input  wire logic       rx_overrun_hit,
    output logic            transmit_enable,
    output logic            receive_enable,
    output logic            transmit_teardown_strobe,
    output logic [2:0]      transmit_teardown_channel,
    output logic            receive_teardown_strobe,
    output logic [2:0]      receive_teardown_channel,
    output logic            dma_soft_reset,
    output logic            copy_overrun_frames_enable,
    output logic            idle_request,
    output logic            descriptor_length_write_block,
    output logic            rx_ownership_value,
    output logic            transmit_arbitration_type,
    output logic            tx_next_valid,
    output logic [2:0]      tx_next_channel,
    output logic            rx_overrun_discard,
    output logic            idle_status
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int W     = 37;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_depth_check
        $error("DEPTH must be a power of two, at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // Request buffer
    logic [W-1:0]   fifo_mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic           push;
    logic           pop;
    logic [W-1:0]   head;
    logic           hd_write;
    pdc_idx_t       hd_idx;
    logic [31:0]    hd_data;
    logic           wr;

    assign bus.req_ready = count_reg != (PTR_W + 1)'(DEPTH);
    assign push     = bus.req_valid && bus.req_ready;
    assign pop      = (count_reg != '0) && (!bus.rsp_valid || bus.rsp_ready);
    assign head     = fifo_mem[rd_ptr_reg];
    assign hd_write = head[W-1];
    assign hd_idx   = head[35:32];
    assign hd_data  = head[31:0];
    assign wr       = pop && hd_write;

    always_ff @(posedge mclk)
    begin
        if (push)
            fifo_mem[wr_ptr_reg] <= {bus.req_write, bus.req_index,
                                     bus.req_wdata};
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (PTR_W + 1)'(push)
                                   - (PTR_W + 1)'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft reset sequencing
    pdc_srst_t srst_state_reg;
    logic      idle_now;
    logic      srst_apply;
    logic      srst_write;
    logic      ctl_rst;

    assign idle_now   = !tx_active && !rx_active;
    assign srst_write = wr && (hd_idx == `PDC_IDX_SRST)
                        && hd_data[`PDC_SRST_BIT];
    // Held off until both engines idle [RL8]
    assign srst_apply = (srst_state_reg == PDC_SR_PEND) && idle_now;
    assign ctl_rst    = sys_rst || srst_apply;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            srst_state_reg <= PDC_SR_RUN;
        else
        begin
            unique case (srst_state_reg)
                PDC_SR_RUN:
                    if (srst_write)
                        srst_state_reg <= PDC_SR_PEND;
                // Set wins in apply cycle
                PDC_SR_PEND:
                    if (srst_apply && !srst_write)
                        srst_state_reg <= PDC_SR_RUN;
                default:
                    srst_state_reg <= PDC_SR_RUN;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            dma_soft_reset <= 1'b0;
        else
            dma_soft_reset <= srst_apply; // [RL7]
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers, loaded with reset values by soft reset too
    logic       tx_en_reg;
    logic       rx_en_reg;
    logic [4:0] dmactl_reg;

    always_ff @(posedge mclk)
    begin
        if (ctl_rst)
        begin
            tx_en_reg  <= `PDC_RST_EN;
            rx_en_reg  <= `PDC_RST_EN;
            dmactl_reg <= `PDC_RST_DMACTL;
        end
        else if (wr)
        begin
            if (hd_idx == `PDC_IDX_TX_CTRL)
                tx_en_reg <= hd_data[`PDC_EN_BIT]; // [RL1]
            if (hd_idx == `PDC_IDX_RX_CTRL)
                rx_en_reg <= hd_data[`PDC_EN_BIT]; // [RL1]
            if (hd_idx == `PDC_IDX_DMACTL)
                dmactl_reg <= hd_data[4:0]; // [RL18]
        end
    end

    assign transmit_enable               = tx_en_reg;
    assign receive_enable                = rx_en_reg;
    assign copy_overrun_frames_enable    = dmactl_reg[`PDC_CEF_BIT];
    assign idle_request  = !dmactl_reg[`PDC_IDLE_CMD_BIT]; // [RL12]
    // Length word writes gated by this bit [RL13] [RL14]
    assign descriptor_length_write_block = dmactl_reg[`PDC_OFFLEN_BIT];
    assign rx_ownership_value = dmactl_reg[`PDC_OWN_BIT]; // [RL15]
    assign transmit_arbitration_type     = dmactl_reg[`PDC_PTYPE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Teardown commands; one-cycle strobes
    always_ff @(posedge mclk)
    begin
        if (ctl_rst)
        begin
            transmit_teardown_strobe  <= 1'b0;
            transmit_teardown_channel <= 3'h0;
            receive_teardown_strobe   <= 1'b0;
            receive_teardown_channel  <= 3'h0;
        end
        else
        begin
            transmit_teardown_strobe <= wr && hd_idx == `PDC_IDX_TX_TDN;
            receive_teardown_strobe  <= wr && hd_idx == `PDC_IDX_RX_TDN;
            if (wr && hd_idx == `PDC_IDX_TX_TDN)
                transmit_teardown_channel <= hd_data[2:0]; // [RL2]
            if (wr && hd_idx == `PDC_IDX_RX_TDN)
                receive_teardown_channel <= hd_data[2:0]; // [RL3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit channel selection
    logic [2:0] last_ch_reg;
    logic [2:0] pick;
    logic [2:0] cand;

    always_comb
    begin
        pick = 3'h0;
        cand = 3'h0;
        if (transmit_arbitration_type)
        begin
            for (int i = 0; i < 8; i++)
                if (tx_channel_pending[i])
                    pick = 3'(i); // [RL16]
        end
        else
        begin
            // Downward scan: nearest after last served wins
            for (int k = 8; k > 0; k--)
            begin
                cand = last_ch_reg + 3'(k);
                if (tx_channel_pending[cand])
                    pick = cand; // [RL16]
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (ctl_rst)
        begin
            tx_next_valid   <= 1'b0;
            tx_next_channel <= 3'h0;
            last_ch_reg     <= 3'h7;
        end
        else
        begin
            tx_next_valid   <= |tx_channel_pending;
            tx_next_channel <= pick;
            if (tx_channel_take)
                last_ch_reg <= tx_next_channel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Overrun handling and idle status
    always_ff @(posedge mclk)
    begin
        if (ctl_rst)
        begin
            rx_overrun_discard <= 1'b0;
            idle_status        <= 1'b0;
        end
        else
        begin
            // Other errors never enter here [RL10] [RL11]
            rx_overrun_discard <= rx_overrun_hit
                                  && !copy_overrun_frames_enable;
            idle_status <= idle_now; // [RL17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and answer
    logic [31:0] rdata_next;
    logic        rsp_valid_reg;
    logic [31:0] rsp_rdata_reg;

    always_comb
    begin
        rdata_next = 32'h0; // [RL18]
        if (!hd_write)
        begin
            unique case (hd_idx)
                `PDC_IDX_TRANSMIT_IDENTIFICATION_VERSION:
                    rdata_next = {TX_IDENT, TX_MAJOR, TX_MINOR}; // [RL6]
                `PDC_IDX_RECEIVE_IDENTIFICATION_VERSION:
                    rdata_next = {RX_IDENT, RX_MAJOR, RX_MINOR}; // [RL6]
                `PDC_IDX_TX_CTRL:
                    rdata_next[`PDC_EN_BIT] = tx_en_reg;
                `PDC_IDX_RX_CTRL:
                    rdata_next[`PDC_EN_BIT] = rx_en_reg;
                // Teardown and ready flag read zero [RL4] [RL5]
                `PDC_IDX_TX_TDN,
                `PDC_IDX_RX_TDN:
                    rdata_next = 32'h0;
                `PDC_IDX_SRST:
                    rdata_next[`PDC_SRST_BIT] =
                        (srst_state_reg == PDC_SR_PEND); // [RL9]
                `PDC_IDX_DMACTL:
                    rdata_next[4:0] = dmactl_reg;
                `PDC_IDX_STATUS:
                    rdata_next[`PDC_STAT_IDLE_BIT] = idle_status;
                default:
                    rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 32'h0;
        end
        else if (pop)
        begin
            rsp_valid_reg <= 1'b1;
            rsp_rdata_reg <= rdata_next;
        end
        else if (bus.rsp_ready)
            rsp_valid_reg <= 1'b0;
    end

    assign bus.rsp_valid = rsp_valid_reg;
    assign bus.rsp_rdata = rsp_rdata_reg;
endmodule // pdc_device
`default_nettype wire

// >>> core/pdc_consts.svh
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH
// Register indexes
`define PDC_IDX_TRANSMIT_IDENTIFICATION_VERSION   4'h0
`define PDC_IDX_TX_CTRL    4'h1
`define PDC_IDX_TX_TDN     4'h2
`define PDC_IDX_RECEIVE_IDENTIFICATION_VERSION   4'h4
`define PDC_IDX_RX_CTRL    4'h5
`define PDC_IDX_RX_TDN     4'h6
`define PDC_IDX_SRST       4'h7
`define PDC_IDX_DMACTL     4'h8
`define PDC_IDX_STATUS     4'h9
// Field positions
`define PDC_EN_BIT         0
`define PDC_TDN_CH_MSB     2
`define PDC_SRST_BIT       0
`define PDC_CEF_BIT        4
`define PDC_IDLE_CMD_BIT   3
`define PDC_OFFLEN_BIT     2
`define PDC_OWN_BIT        1
`define PDC_PTYPE_BIT      0
`define PDC_STAT_IDLE_BIT  31
// Reset values
`define PDC_RST_EN         1'h0
`define PDC_RST_DMACTL     5'h08
`endif

// >>> core/pdc_pkg.sv
package pdc_pkg;
    typedef logic [3:0] pdc_idx_t;
    typedef enum logic [1:0]
    {
        PDC_SR_RUN  = 2'b01,
        PDC_SR_PEND = 2'b10
    } pdc_srst_t;
endpackage

// >>> core/pdc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pdc_if;
    import pdc_pkg::*;
    logic        req_valid;
    logic        req_ready;
    logic        req_write;
    pdc_idx_t    req_index;
    logic [31:0] req_wdata;
    logic        rsp_valid;
    logic        rsp_ready;
    logic [31:0] rsp_rdata;
    modport device
    (
        input  req_valid, req_write, req_index, req_wdata, rsp_ready,
        output req_ready, rsp_valid, rsp_rdata
    );
    modport host
    (
        output req_valid, req_write, req_index, req_wdata, rsp_ready,
        input  req_ready, rsp_valid, rsp_rdata
    );
endinterface
`default_nettype wire

// >>> core/pdc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_host
    import pdc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    pdc_if.host              bus,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire pdc_idx_t    cmd_index,
    input  wire logic [31:0] cmd_wdata,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [31:0]      rd_data
);
    logic        req_valid_reg;
    logic        req_write_reg;
    pdc_idx_t    req_index_reg;
    logic [31:0] req_wdata_reg;
    logic        rd_valid_reg;
    logic [31:0] rd_data_reg;
    logic        is_tdn;

    ////////////////////////////////////////////////////////////////////////
    // Request side
    assign cmd_ready = !req_valid_reg || bus.req_ready;
    // Never polled; always ready [RL5]
    assign is_tdn = (cmd_index == `PDC_IDX_TX_TDN)
                 || (cmd_index == `PDC_IDX_RX_TDN);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            req_valid_reg <= 1'b0;
        else if (cmd_ready)
            req_valid_reg <= cmd_valid;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            req_write_reg <= 1'b0;
            req_index_reg <= 4'h0;
            req_wdata_reg <= 32'h0;
        end
        else if (cmd_ready && cmd_valid)
        begin
            req_write_reg <= cmd_write;
            req_index_reg <= cmd_index;
            // Channel only in bits 2..0 [RL2] [RL3]
            req_wdata_reg <= is_tdn
                ? {29'h0, cmd_wdata[`PDC_TDN_CH_MSB:0]} : cmd_wdata;
        end
    end

    assign bus.req_valid = req_valid_reg;
    assign bus.req_write = req_write_reg;
    assign bus.req_index = req_index_reg;
    assign bus.req_wdata = req_wdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Answer side; stall backs up
    assign bus.rsp_ready = !rd_valid_reg || rd_ready;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= 32'h0;
        end
        else if (bus.rsp_ready)
        begin
            rd_valid_reg <= bus.rsp_valid;
            if (bus.rsp_valid)
                rd_data_reg <= bus.rsp_rdata;
        end
    end

    assign rd_valid = rd_valid_reg;
    assign rd_data  = rd_data_reg;
endmodule // pdc_host
`default_nettype wire

// >>> bench/pdc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_checker
    import pdc_pkg::*;
#(
    parameter logic [31:0] TX_ID = 32'h1234_0100, // Arbitrary value
    parameter logic [31:0] RX_ID = 32'h1235_0100  // Arbitrary value
)
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire pdc_idx_t    req_index,
    input wire logic [31:0] req_wdata,
    input wire logic        rsp_valid,
    input wire logic        rsp_ready,
    input wire logic [31:0] rsp_rdata
);
    logic [4:0] kind_q [0:3];
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic       take;
    logic       rd_ans;
    pdc_idx_t   ans_idx;
    assign take    = req_valid && req_ready;
    assign rd_ans  = rsp_valid && !kind_q[rd_ptr][4];
    assign ans_idx = kind_q[rd_ptr][3:0];
    ////////////////////////////////////////////////////////////////////////
    // Four slots; at most three in flight
    always_ff @(posedge mclk)
    begin
        if (take)
            kind_q[wr_ptr] <= {req_write, req_index};
    end
    always_ff @(posedge mclk)
    begin
        wr_ptr <= sys_rst ? 2'h0 : wr_ptr + 2'(take);
        rd_ptr <= sys_rst ? 2'h0 : rd_ptr + 2'(rsp_valid && rsp_ready);
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    property p_tx_ident;
        rd_ans && ans_idx == `PDC_IDX_TRANSMIT_IDENTIFICATION_VERSION |-> rsp_rdata == TX_ID;
    endproperty
    a_tx_ident: assert property (p_tx_ident)
        else $error("tx ident");
    property p_rx_ident;
        rd_ans && ans_idx == `PDC_IDX_RECEIVE_IDENTIFICATION_VERSION |-> rsp_rdata == RX_ID;
    endproperty
    a_rx_ident: assert property (p_rx_ident)
        else $error("rx ident");
    property p_tdn_zero;
        rd_ans && (ans_idx == `PDC_IDX_TX_TDN || ans_idx == `PDC_IDX_RX_TDN)
        |-> rsp_rdata == 32'h0;
    endproperty
    a_tdn_zero: assert property (p_tdn_zero)
        else $error("teardown read not zero");
    property p_ctrl_rsv;
        rd_ans && (ans_idx == `PDC_IDX_TX_CTRL || ans_idx == `PDC_IDX_RX_CTRL)
        |-> rsp_rdata[31:1] == 31'h0;
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv)
        else $error("control reserved bits set");
    property p_srst_rsv;
        rd_ans && ans_idx == `PDC_IDX_SRST |-> rsp_rdata[31:1] == 31'h0;
    endproperty
    a_srst_rsv: assert property (p_srst_rsv)
        else $error("srst reserved");
    property p_dmactl_rsv;
        rd_ans && ans_idx == `PDC_IDX_DMACTL |-> rsp_rdata[31:5] == 27'h0;
    endproperty
    a_dmactl_rsv: assert property (p_dmactl_rsv)
        else $error("option reserved bits set");
    property p_unmapped;
        rd_ans && (ans_idx == 4'h3 || ans_idx > 4'h9) |-> rsp_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    // Held through a stall
    property p_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_rdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("answer dropped");
    c_tdn: cover property (rd_ans && ans_idx == `PDC_IDX_TX_TDN);
    c_full: cover property (req_valid && !req_ready);
    c_srst: cover property (take && req_write && req_index == `PDC_IDX_SRST);
endmodule // pdc_checker
`default_nettype wire

// >>> bench/packet_dma_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"
module packet_dma_control_test
    import pdc_pkg::*;
;
    logic        mclk;
    logic        sys_rst;
    logic        cmd_valid, cmd_ready, cmd_write;
    pdc_idx_t    cmd_index;
    logic [31:0] cmd_wdata;
    logic        rd_valid, rd_ready;
    logic [31:0] rd_data;
    logic        tx_active, rx_active, tx_channel_take, rx_overrun_hit;
    logic [7:0]  tx_channel_pending;
    logic        transmit_enable, receive_enable, dma_soft_reset;
    logic        transmit_teardown_strobe, receive_teardown_strobe;
    logic [2:0]  transmit_teardown_channel, receive_teardown_channel;
    logic        copy_overrun_frames_enable, idle_request;
    logic        descriptor_length_write_block, rx_ownership_value;
    logic        transmit_arbitration_type, tx_next_valid;
    logic [2:0]  tx_next_channel;
    logic        rx_overrun_discard, idle_status;
    logic [2:0]  tx_ch, rx_ch;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0, tx_cnt = 0, rx_cnt = 0, srst_cnt = 0, ans_cnt = 0;
    pdc_if i_pdc_if ();
    pdc_host i_pdc_host (.mclk, .sys_rst, .bus(i_pdc_if), .cmd_valid,
        .cmd_ready, .cmd_write, .cmd_index, .cmd_wdata, .rd_valid, .rd_ready,
        .rd_data);
    pdc_device i_pdc_device (.mclk, .sys_rst, .bus(i_pdc_if), .tx_active,
        .rx_active, .tx_channel_pending, .tx_channel_take, .rx_overrun_hit,
        .transmit_enable, .receive_enable, .transmit_teardown_strobe,
        .transmit_teardown_channel, .receive_teardown_strobe,
        .receive_teardown_channel, .dma_soft_reset,
        .copy_overrun_frames_enable, .idle_request,
        .descriptor_length_write_block, .rx_ownership_value,
        .transmit_arbitration_type, .tx_next_valid, .tx_next_channel,
        .rx_overrun_discard, .idle_status);
    pdc_checker i_pdc_checker (.mclk, .sys_rst,
        .req_valid(i_pdc_if.req_valid), .req_ready(i_pdc_if.req_ready),
        .req_write(i_pdc_if.req_write), .req_index(i_pdc_if.req_index),
        .req_wdata(i_pdc_if.req_wdata), .rsp_valid(i_pdc_if.rsp_valid),
        .rsp_ready(i_pdc_if.rsp_ready), .rsp_rdata(i_pdc_if.rsp_rdata));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Sampled clear of both edges
    always @(negedge mclk)
    begin
        #2;
        cycles++;
        if (transmit_teardown_strobe === 1'b1)
        begin
            tx_cnt++;
            tx_ch = transmit_teardown_channel;
        end
        if (receive_teardown_strobe === 1'b1)
        begin
            rx_cnt++;
            rx_ch = receive_teardown_channel;
        end
        if (dma_soft_reset === 1'b1)
            srst_cnt++;
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
            ans_cnt++;
        if (cycles == 8000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_take;
        int n = 0;
        while (cmd_ready !== 1'b1 && n < 50)
        begin
            @(negedge mclk);
            n++;
        end
        chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
        @(negedge mclk);
    endtask
    task automatic xfer(input logic w, input pdc_idx_t idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n = 0;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_index = idx;
        cmd_wdata = wd;
        wait_take();
        cmd_valid = 1'b0;
        while (rd_valid !== 1'b1 && n < 50)
        begin
            @(negedge mclk);
            n++;
        end
        rd = rd_data;
        chk("rd_valid", 32'h1, {31'h0, rd_valid});
        @(negedge mclk);
    endtask
    task automatic rd_chk(input string nm, input pdc_idx_t idx,
                          input logic [31:0] e);
        logic [31:0] v;
        xfer(1'b0, idx, 32'h0, v);
        chk(nm, e, v);
    endtask
    task automatic wr(input pdc_idx_t idx, input logic [31:0] wd);
        logic [31:0] v;
        xfer(1'b1, idx, wd, v);
        chk("write answer", 32'h0, v);
    endtask
    task automatic outs(input logic [31:0] e);
        chk("options", e, {27'h0, copy_overrun_frames_enable, idle_request,
            descriptor_length_write_block, rx_ownership_value,
            transmit_arbitration_type});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_basics;
        wr(`PDC_IDX_TRANSMIT_IDENTIFICATION_VERSION, 32'hffff_ffff);
        rd_chk("tx ident", `PDC_IDX_TRANSMIT_IDENTIFICATION_VERSION, 32'h1234_0100);
        rd_chk("rx ident", `PDC_IDX_RECEIVE_IDENTIFICATION_VERSION, 32'h1235_0100);
        rd_chk("soft reset", `PDC_IDX_SRST, 32'h0);
        rd_chk("options", `PDC_IDX_DMACTL, 32'h8);
        wr(`PDC_IDX_TX_CTRL, 32'hffff_ffff);
        rd_chk("tx ctrl", `PDC_IDX_TX_CTRL, 32'h1);
        chk("rx en", 32'h0, {31'h0, receive_enable});
        wr(`PDC_IDX_RX_CTRL, 32'h1);
        wr(`PDC_IDX_TX_CTRL, 32'h0);
        chk("en pair", 32'h1, {30'h0, transmit_enable, receive_enable});
        wr(4'hf, 32'hffff_ffff);
        rd_chk("unmapped", 4'hf, 32'h0);
    endtask
    task automatic t_teardown;
        int t, r;
        for (int k = 0; k < 8; k++)
        begin
            t = tx_cnt;
            r = rx_cnt;
            wr(`PDC_IDX_TX_TDN, 32'hffff_fff8 | 32'(k));
            wr(`PDC_IDX_RX_TDN, 32'(k));
            chk("tx tdn", 32'(t + 1), 32'(tx_cnt));
            chk("tx ch", 32'(k), {29'h0, tx_ch});
            chk("rx tdn", 32'(r + 1), 32'(rx_cnt));
            chk("rx ch", 32'(k), {29'h0, rx_ch});
        end
        rd_chk("tx tdn read", `PDC_IDX_TX_TDN, 32'h0);
        rd_chk("rx tdn read", `PDC_IDX_RX_TDN, 32'h0);
    endtask
    task automatic t_options;
        wr(`PDC_IDX_DMACTL, 32'hffff_ffff);
        rd_chk("options", `PDC_IDX_DMACTL, 32'h1f);
        outs(32'h17);
        rx_overrun_hit = 1'b1;
        repeat (3) @(negedge mclk);
        chk("discard", 32'h0, {31'h0, rx_overrun_discard});
        wr(`PDC_IDX_DMACTL, 32'h0);
        outs(32'h08);
        chk("discard", 32'h1, {31'h0, rx_overrun_discard});
        rx_overrun_hit = 1'b0;
    endtask
    task automatic t_arbiter;
        tx_channel_pending = 8'b0000_0110;
        repeat (3) @(negedge mclk);
        chk("rr first", 32'h9, {28'h0, tx_next_valid, tx_next_channel});
        tx_channel_take = 1'b1;
        @(negedge mclk);
        tx_channel_take = 1'b0;
        repeat (3) @(negedge mclk);
        chk("rr next", 32'h2, {29'h0, tx_next_channel});
        wr(`PDC_IDX_DMACTL, 32'h1);
        tx_channel_pending = 8'b1000_0101;
        repeat (3) @(negedge mclk);
        chk("fixed top", 32'h7, {29'h0, tx_next_channel});
        tx_channel_pending = 8'b0000_0101;
        repeat (3) @(negedge mclk);
        chk("fixed low", 32'h2, {29'h0, tx_next_channel});
        tx_channel_pending = 8'h00;
    endtask
    task automatic t_reset;
        int b;
        rx_active = 1'b1;
        rd_chk("status busy", `PDC_IDX_STATUS, 32'h0);
        b = srst_cnt;
        wr(`PDC_IDX_TX_CTRL, 32'h1);
        wr(`PDC_IDX_SRST, 32'h1);
        repeat (5) @(negedge mclk);
        rd_chk("pending", `PDC_IDX_SRST, 32'h1);
        chk("held off", 32'(b), 32'(srst_cnt));
        rx_active = 1'b0;
        repeat (4) @(negedge mclk);
        rd_chk("done", `PDC_IDX_SRST, 32'h0);
        chk("applied", 32'(b + 1), 32'(srst_cnt));
        chk("tx en", 32'h0, {31'h0, transmit_enable});
        rd_chk("options", `PDC_IDX_DMACTL, 32'h8);
        rd_chk("status idle", `PDC_IDX_STATUS, 32'h8000_0000);
    endtask
    // Stall must back up, not lose
    task automatic t_fill;
        int n = 0;
        int b = ans_cnt;
        rd_ready = 1'b0;
        cmd_valid = 1'b1;
        cmd_write = 1'b1;
        cmd_index = `PDC_IDX_DMACTL;
        cmd_wdata = 32'h0;
        while (n < 16 && cmd_ready === 1'b1)
        begin
            @(negedge mclk);
            n++;
            cmd_wdata = 32'(n);
        end
        chk("refusal", 32'h1, 32'(n < 16));
        rd_ready = 1'b1;
        wait_take();
        cmd_valid = 1'b0;
        repeat (40) @(negedge mclk);
        chk("answers", 32'(n + 1), 32'(ans_cnt - b));
        chk("drained", 32'h0, {31'h0, rd_valid});
        rd_chk("last write", `PDC_IDX_DMACTL, 32'(n) & 32'h1f);
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_index = 4'h0;
        cmd_wdata = 32'h0;
        rd_ready = 1'b1;
        tx_active = 1'b0;
        rx_active = 1'b0;
        tx_channel_pending = 8'h00;
        tx_channel_take = 1'b0;
        rx_overrun_hit = 1'b0;
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        t_basics();
        t_teardown();
        t_options();
        t_arbiter();
        t_reset();
        t_fill();
        wrap_up();
    end
endmodule // packet_dma_control_test
`default_nettype wire
